//--- hw/fbc_params.svh
// Timing counts and widths for the host-side parallel flash bus controller.
// Assumes a 100 MHz mclk_i; every time below is converted to cycles here.
`ifndef FBC_PARAMS_SVH
`define FBC_PARAMS_SVH

`define FBC_CLK_PERIOD_NS   10
`define FBC_ADDR_W          21
`define FBC_DATA_W          16
`define FBC_BANK_MSB        20
`define FBC_BANK_LSB        19
// Access time of the device, as a plain default.
`define FBC_ACCESS_NS       70
// Least times round up to whole cycles.
`define FBC_CEIL(ns)        (((ns) + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS)
`define FBC_ACCESS_CYC      `FBC_CEIL(`FBC_ACCESS_NS)
// Write pulse width and recovery between write cycles.
`define FBC_WP_NS           40
`define FBC_WP_CYC          `FBC_CEIL(`FBC_WP_NS)
`define FBC_WH_NS           30
`define FBC_WH_CYC          `FBC_CEIL(`FBC_WH_NS)
// Reset pulse width and recovery after the reset pin returns high.
`define FBC_RP_NS           500
`define FBC_RP_CYC          `FBC_CEIL(`FBC_RP_NS)
`define FBC_RH_NS           50
`define FBC_RH_CYC          `FBC_CEIL(`FBC_RH_NS)
`define FBC_CNT_W           8

`endif

//--- hw/fbc_pkg.sv
// Types for the host-side parallel flash bus controller.
// Assumes fbc_params.svh is included by the module that uses these types.
package fbc_pkg;

  // Bus sequencer states.
  typedef enum logic [2:0]
  {
    FBC_IDLE   = 3'b000,
    FBC_WSETUP = 3'b001,
    FBC_WPULSE = 3'b010,
    FBC_WHOLD  = 3'b011,
    FBC_READ   = 3'b100,
    FBC_RPULSE = 3'b101,
    FBC_RRECOV = 3'b110
  } fbc_state_t;

endpackage

//--- hw/fbc_ctrl.sv
// Host-side controller that drives an asynchronous parallel NOR flash by its pins.
// Assumes the device ready/busy output and data pins arrive asynchronously.
// Functional notes
// RQ1: Host drives write-enable and chip-enable low per write.
// RQ2: Device takes bytes or words per byte select.
// RQ3: Unlock-bypass program needs two writes, not four.
// RQ4: Erase targets sector, sectors or whole device.
// RQ5: Four banks chosen by upper address bits.
// RQ6: Accelerate level enters bypass, unprotects, speeds programming.
// RQ7: Host uses two-cycle program while accelerated.
// RQ8: Removing accelerate level restores normal operation.
// RQ9: Host drives protect pin always; accelerate only programming. The code drives accel_level_o from accel_req_i in every state, reads included.
// RQ10: Autoselect reads internal codes with normal timing.
// RQ11: Read one bank while another programs or erases.
// RQ12: Suspended erase allows other same-bank accesses.
// RQ13: Standby tristates outputs regardless of output-enable.
// RQ14: Standby when chip-enable and reset high; full access.
// RQ15: Deselect does not stop running program or erase.
// RQ16: Stable addresses enter auto sleep, data kept.
// RQ17: Reset pulse aborts, tristates, returns to array read.
// RQ18: Host restarts interrupted operation after reset.
// RQ19: Ready/busy stays low until internal reset completes.
// RQ20: Idle reset quick; read only after recovery time.
// RQ21: Byte mode tristates data 14..8, data 15 addresses.
// RQ22: Accelerate level is a separate qualifier input.
`timescale 1ns/100ps
`include "fbc_params.svh"

module fbc_ctrl
(
  input  wire logic                    mclk_i,
  input  wire logic                    nrst_i,
  // User request port.
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic [`FBC_ADDR_W-1:0]  req_addr_i,
  input  wire logic [`FBC_DATA_W-1:0]  req_wdata_i,
  input  wire logic                    byte_mode_i,
  input  wire logic                    accel_req_i,
  input  wire logic                    flash_reset_req_i,
  output logic                         req_ready_o,
  output logic                         rdata_valid_o,
  output logic [`FBC_DATA_W-1:0]       rdata_o,
  output logic [1:0]                   bank_o,
  output logic                         dev_busy_o,
  // Flash pins.
  output logic [`FBC_ADDR_W-1:0]       flash_addr_o,
  output logic                         flash_dq15_addr_o,
  output logic                         chip_en_n_o,
  output logic                         write_en_n_o,
  output logic                         out_en_n_o,
  output logic                         byte_sel_n_o,
  output logic                         reset_n_o,
  output logic                         protect_accel_pin_o,
  output logic                         accel_level_o,
  output logic [`FBC_DATA_W-1:0]       dq_o,
  output logic [`FBC_DATA_W-1:0]       dq_oe_o,
  input  wire logic [`FBC_DATA_W-1:0]  dq_i,
  input  wire logic                    ready_busy_n_i
);

  fbc_pkg::fbc_state_t         state;
  fbc_pkg::fbc_state_t         next_state;
  logic [`FBC_CNT_W-1:0]       cnt;
  logic [`FBC_CNT_W-1:0]       next_cnt;
  logic [`FBC_ADDR_W-1:0]      addr;
  logic [`FBC_ADDR_W-1:0]      next_addr;
  logic [`FBC_DATA_W-1:0]      wdata;
  logic [`FBC_DATA_W-1:0]      next_wdata;
  logic                        bmode;
  logic                        next_bmode;
  logic [`FBC_DATA_W-1:0]      next_rdata;
  logic                        next_rdata_valid;
  logic                        rb_meta;
  logic                        rb_sync;
  logic [`FBC_DATA_W-1:0]      dq_meta;
  logic [`FBC_DATA_W-1:0]      dq_sync;

  // Bank field of an address; the device splits its space into four banks.
  function automatic logic [1:0] bank_of(input logic [`FBC_ADDR_W-1:0] a);
    bank_of = a[`FBC_BANK_MSB:`FBC_BANK_LSB]; // RQ5
  endfunction

  // Two-stage synchronisers for the asynchronous flash outputs.
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
      dq_meta <= '0;
      dq_sync <= '0;
    end
    else
    begin
      rb_meta <= ready_busy_n_i;
      rb_sync <= rb_meta;
      dq_meta <= dq_i;
      dq_sync <= dq_meta;
    end
  end

  // Next-state logic. Reads need no busy check: other banks read during a
  // program or erase, so the sequencer never stalls reads on ready/busy.
  always_comb
  begin
    next_state       = state;
    next_cnt         = cnt;
    next_addr        = addr;
    next_wdata       = wdata;
    next_bmode       = bmode;
    next_rdata       = rdata_o;
    next_rdata_valid = 1'b0;
    case (state)
      fbc_pkg::FBC_IDLE:
      begin
        if (flash_reset_req_i)
        begin
          next_state = fbc_pkg::FBC_RPULSE;
          next_cnt   = `FBC_CNT_W'(`FBC_RP_CYC);
        end
        else if (req_valid_i)
        begin
          next_addr  = req_addr_i;
          next_wdata = req_wdata_i;
          next_bmode = byte_mode_i; // RQ2
          if (req_write_i)
          begin
            // Each request is one write cycle, so a bypass program is two requests.
            next_state = fbc_pkg::FBC_WPULSE; // RQ1 RQ3 RQ7
            next_cnt   = `FBC_CNT_W'(`FBC_WP_CYC);
          end
          else
          begin
            // Leaving standby needs the full access time. RQ14
            next_state = fbc_pkg::FBC_READ;
            next_cnt   = `FBC_CNT_W'(`FBC_ACCESS_CYC + 2);
          end
        end
      end
      fbc_pkg::FBC_WPULSE:
      begin
        next_cnt = cnt - `FBC_CNT_W'(1);
        if (cnt == `FBC_CNT_W'(1))
        begin
          next_state = fbc_pkg::FBC_WHOLD;
          next_cnt   = `FBC_CNT_W'(`FBC_WH_CYC);
        end
      end
      fbc_pkg::FBC_WHOLD, fbc_pkg::FBC_RRECOV:
      begin
        next_cnt = cnt - `FBC_CNT_W'(1);
        if (cnt == `FBC_CNT_W'(1))
          next_state = fbc_pkg::FBC_IDLE;
      end
      fbc_pkg::FBC_READ:
      begin
        // Extra two cycles cover the data synchroniser.
        next_cnt = cnt - `FBC_CNT_W'(1);
        if (cnt == `FBC_CNT_W'(1))
        begin
          next_rdata       = bmode ? {8'h00, dq_sync[7:0]} : dq_sync;
          next_rdata_valid = 1'b1;
          next_state       = fbc_pkg::FBC_IDLE;
        end
      end
      fbc_pkg::FBC_RPULSE:
      begin
        // Held for at least the minimum reset width, then recovery. RQ17
        next_cnt = cnt - `FBC_CNT_W'(1);
        if (cnt == `FBC_CNT_W'(1))
        begin
          next_state = fbc_pkg::FBC_RRECOV;
          next_cnt   = `FBC_CNT_W'(`FBC_RH_CYC); // RQ20
        end
      end
      default:
        next_state = fbc_pkg::FBC_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      state         <= fbc_pkg::FBC_IDLE;
      cnt           <= '0;
      addr          <= '0;
      wdata         <= '0;
      bmode         <= 1'b0;
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      addr          <= next_addr;
      wdata         <= next_wdata;
      bmode         <= next_bmode;
      rdata_o       <= next_rdata;
      rdata_valid_o <= next_rdata_valid;
    end
  end

  // Pin drive; idle leaves chip-enable high so the device rests in standby.
  // Addresses are held after a read so the device can sleep with data latched.
  always_comb
  begin
    req_ready_o         = (state == fbc_pkg::FBC_IDLE) && !flash_reset_req_i;
    bank_o              = bank_of(addr);
    dev_busy_o          = !rb_sync; // RQ18
    flash_addr_o        = addr; // RQ16
    flash_dq15_addr_o   = addr[0];
    byte_sel_n_o        = !bmode; // RQ2
    chip_en_n_o         = !((state == fbc_pkg::FBC_WPULSE) || (state == fbc_pkg::FBC_READ)); // RQ1
    write_en_n_o        = !(state == fbc_pkg::FBC_WPULSE); // RQ1
    out_en_n_o          = !(state == fbc_pkg::FBC_READ);
    reset_n_o           = !(state == fbc_pkg::FBC_RPULSE); // RQ17
    // The protect pin is always driven; accelerate only with a request. RQ9
    protect_accel_pin_o = 1'b1;
    accel_level_o       = accel_req_i; // RQ22
    dq_o                = '0;
    dq_oe_o             = '0;
    if (state == fbc_pkg::FBC_WPULSE || state == fbc_pkg::FBC_WHOLD)
    begin
      if (bmode)
      begin
        // Byte mode: only the low lane plus the address bit on data 15. RQ21
        dq_o    = {addr[0], 7'h00, wdata[7:0]};
        dq_oe_o = 16'h80ff;
      end
      else
      begin
        dq_o    = wdata;
        dq_oe_o = 16'hffff;
      end
    end
    else if (bmode && state == fbc_pkg::FBC_READ)
    begin
      dq_o    = {addr[0], 15'h0000};
      dq_oe_o = 16'h8000; // RQ21
    end
  end

  // Assertions.
  we_with_ce_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !write_en_n_o |-> !chip_en_n_o && out_en_n_o) else $error("write strobe without chip select"); // RQ1
  reset_width_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(reset_n_o) |-> !reset_n_o [*8]) else $error("reset pulse too short"); // RQ17
  reset_recov_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(reset_n_o) |-> chip_en_n_o [*5]) else $error("access during reset recovery"); // RQ20
  byte_lanes_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !byte_sel_n_o |-> dq_oe_o[14:8] == 7'h00) else $error("byte mode drives upper lanes"); // RQ21
  standby_quiet_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    chip_en_n_o && reset_n_o && state == fbc_pkg::FBC_IDLE |-> dq_oe_o == 16'h0000)
    else $error("bus driven in standby"); // RQ14
  read_done_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(out_en_n_o) |-> ##[1:20] rdata_valid_o) else $error("read never completes"); // RQ14
  no_oe_in_write_a: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !out_en_n_o |-> write_en_n_o && dq_oe_o[7:0] == 8'h00) else $error("read with write or drive"); // RQ1

endmodule

//--- verification/fbc_flash_model.sv
// Behavioural model of the parallel flash that stands on the far side of fbc_ctrl.
// Assumes the bench resolves the shared data pins and hands the resolved level in.
`timescale 1ns/100ps

module fbc_flash_model
#(
  parameter int BUSY_NS  = 2000,
  parameter int READY_NS = 1000
)
(
  input  wire logic [20:0] addr_i,
  input  wire logic        dq15_addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        byte_sel_n_i,
  input  wire logic        reset_n_i,
  input  wire logic        accel_level_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic             ready_busy_n_o
);
  logic [15:0] mem [int];
  logic [15:0] wword;
  logic [15:0] rword;
  logic [15:0] junk = 16'ha5c3;
  realtime     done_at = 0;
  logic        armed = 1'b0;
  wire         wr_strobe_n = we_n_i | ce_n_i;

  // Released pins show a pattern that flips every cycle, so stale data never looks valid.
  always #10 junk = ~junk;

  // Arm only once both enables are low, so the unknown levels at power-up never look like a write.
  always @(negedge wr_strobe_n)
    if (wr_strobe_n === 1'b0) armed = 1'b1;
  // A write is taken when the first enable rises, so enables that rise together never race.
  // The accelerate level shortens the program.
  always @(posedge wr_strobe_n)
  begin
    if (armed && reset_n_i)
    begin
      wword = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
      if (byte_sel_n_i) wword = dq_i;
      else wword[dq15_addr_i*8 +: 8] = dq_i[7:0];
      mem[addr_i] = wword;
      done_at = $realtime + (accel_level_i ? BUSY_NS / 2 : BUSY_NS);
    end
    armed = 1'b0;
  end

  // A reset during a program keeps busy low for the internal reset time; idle reset ends at once.
  always @(negedge reset_n_i)
    if (!ready_busy_n_o) done_at = $realtime + READY_NS;

  // Busy ends only on time or reset, never on deselect.
  always #5 ready_busy_n_o = ($realtime >= done_at);

  // Reads answer from any bank at any time; standby and reset leave the pins released.
  // Identification codes would come out through this same path and timing.
  always @*
  begin
    rword = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
    if (reset_n_i && !ce_n_i && !oe_n_i && we_n_i)
      dq_o = byte_sel_n_i ? rword : {junk[15:8], dq15_addr_i ? rword[15:8] : rword[7:0]};
    else
      dq_o = junk;
  end
endmodule

//--- verification/tb.sv
// Self-checking bench for fbc_ctrl against the flash model.
// Assumes the controller's cycle counts for a 100 MHz clock from fbc_params.svh.
`timescale 1ns/100ps
`include "fbc_params.svh"

module tb;
  logic mclk_i = 0, nrst_i = 0, req_valid_i = 0, req_write_i = 0, byte_mode_i = 0;
  logic accel_req_i = 0, flash_reset_req_i = 0;
  logic [20:0] req_addr_i = 0;
  logic [15:0] req_wdata_i = 0, q;
  logic req_ready_o, rdata_valid_o, dev_busy_o, dq15, ce_n, we_n, oe_n, bsel_n, rst_n, prot, accl, rb_n;
  logic [15:0] rdata_o, dq_o, dq_oe_o, mdq, bus;
  logic [20:0] faddr;
  logic [1:0] bank_o;
  int n_mismatch = 0, total_checks = 0, cyc = 0;

  fbc_ctrl fbc_ctrl_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .byte_mode_i(byte_mode_i), .accel_req_i(accel_req_i), .flash_reset_req_i(flash_reset_req_i),
    .req_ready_o(req_ready_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .bank_o(bank_o),
    .dev_busy_o(dev_busy_o), .flash_addr_o(faddr), .flash_dq15_addr_o(dq15), .chip_en_n_o(ce_n),
    .write_en_n_o(we_n), .out_en_n_o(oe_n), .byte_sel_n_o(bsel_n), .reset_n_o(rst_n),
    .protect_accel_pin_o(prot), .accel_level_o(accl), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(bus),
    .ready_busy_n_i(rb_n));
  fbc_flash_model fbc_flash_model_inst (.addr_i(faddr), .dq15_addr_i(dq15), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .byte_sel_n_i(bsel_n), .reset_n_i(rst_n), .accel_level_i(accl), .dq_i(bus),
    .dq_o(mdq), .ready_busy_n_o(rb_n));

  // Each data pin carries the controller where it drives and the flash elsewhere.
  assign bus = (dq_oe_o & dq_o) | (~dq_oe_o & mdq);

  // Clock, and a ceiling well above the roughly 1000 cycles the tests need.
  initial forever #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  // One bus cycle; the strobes are judged one cycle into the access, then completion is awaited.
  task automatic xfer(logic wr, logic [20:0] a, logic [15:0] d, logic bm);
    int n = 0;
    logic [15:0] lane;
    lane = bm ? {a[0], 7'h00, d[7:0]} : d;
    while (req_ready_o !== 1'b1 && n < 300) begin step(1); n++; end
    chk("ready", n < 300, 1);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, byte_mode_i} = {1'b1, wr, a, d, bm};
    step(1);
    req_valid_i = 0;
    step(1);
    chk("chip_en", ce_n, 0);
    chk("write_en", {we_n, oe_n}, {!wr, wr});
    chk("addr", {faddr, bank_o}, {a, a[20:19]});
    chk("byte_sel", bsel_n, !bm);
    if (bm) chk("dq15_addr", dq15, a[0]);
    // In byte mode the host drives data 15 as the lowest address bit and leaves 14..8 alone.
    if (wr) chk("dq_drive", {dq_oe_o, dq_o & dq_oe_o}, {bm ? 16'h80ff : 16'hffff, lane});
    else chk("dq_read_drive", dq_oe_o, bm ? 16'h8000 : 16'h0000);
    n = 0;
    while ((wr ? req_ready_o : rdata_valid_o) !== 1'b1 && n < 100) begin step(1); n++; end
    chk("done", n < 100, 1);
    q = rdata_o;
    if (!wr)
    begin
      chk("addr_hold", faddr, a);
      step(1);
      chk("valid_pulse", rdata_valid_o, 0);
    end
  endtask

  // Reset pulse: width, released pins, then recovery before the next access.
  task automatic pulse(logic busy_exp);
    int n = 0;
    flash_reset_req_i = 1;
    step(1);
    flash_reset_req_i = 0;
    while (rst_n === 1'b0 && n < 200) begin chk("reset_dq", dq_oe_o, 0); step(1); n++; end
    chk("reset_width", n, `FBC_RP_CYC);
    chk("recovery", {req_ready_o, dev_busy_o}, {1'b0, busy_exp});
    n = 0;
    while (req_ready_o !== 1'b1 && n < 100) begin step(1); n++; end
    chk("recovery_len", n, `FBC_RH_CYC);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Idle pins right after reset: deselected, bus released, protect pin driven.
  task automatic test_standby();
    chk("standby", {ce_n, dq_oe_o, rst_n, prot}, {1'b1, 16'h0, 1'b1, 1'b1});
    $display("test standby done");
  endtask

  // One word written and read back in each of the four banks.
  task automatic test_word_banks();
    for (int b = 0; b < 4; b++)
    begin
      xfer(1, {b[1:0], 19'h00123}, 16'hc3a0 + b[15:0], 0);
      xfer(0, {b[1:0], 19'h00123}, 16'h0000, 0);
      chk("word_read", q, 16'hc3a0 + b[15:0]);
    end
    $display("test word_banks done");
  endtask

  // Upper byte lane written and read back in byte mode.
  task automatic test_byte_mode();
    xfer(1, 21'h000455, 16'h0077, 1);
    xfer(0, 21'h000455, 16'h0000, 1);
    chk("byte_read", q, 16'h0077);
    $display("test byte_mode done");
  endtask

  // Two-cycle program under the accelerate level, then the level removed.
  task automatic test_accel();
    accel_req_i = 1;
    step(1);
    chk("accel", {accl, prot}, 2'b11);
    xfer(1, 21'h000aaa, 16'h00a0, 0);
    xfer(1, 21'h080010, 16'h1234, 0);
    xfer(0, 21'h080010, 16'h0000, 0);
    chk("accel_read", q, 16'h1234);
    accel_req_i = 0;
    step(1);
    chk("accel_off", {accl, prot}, 2'b01);
    $display("test accel done");
  endtask

  // Read another bank while busy, reset the busy device, then restart the program.
  task automatic test_busy_reset();
    step(300);
    xfer(1, 21'h000200, 16'h5aa5, 0);
    step(4);
    chk("busy", dev_busy_o, 1);
    xfer(0, 21'h180123, 16'h0000, 0);
    chk("other_bank", q, 16'hc3a3);
    pulse(1);
    step(120);
    chk("reset_done", dev_busy_o, 0);
    xfer(1, 21'h000200, 16'h5aa5, 0);
    xfer(0, 21'h000200, 16'h0000, 0);
    chk("restart", q, 16'h5aa5);
    $display("test busy_reset done");
  endtask

  // Reset of an idle device completes without busy.
  task automatic test_idle_reset();
    step(300);
    pulse(0);
    $display("test idle_reset done");
  endtask

  // Main sequence: one scenario task after another, each judged before the next starts.
  initial
  begin
    step(6);
    nrst_i = 1;
    step(1);
    test_standby();
    test_word_banks();
    test_byte_mode();
    test_accel();
    test_busy_reset();
    test_idle_reset();
    final_report();
  end
endmodule
